// *** rtl/switch_mode_controller.v ***
// Overview of operation
// - Sleep holds all channels off and all registers but the error latches at reset values.
// - Idle keeps channels off, no diagnosis; register access needs logic supply.
// - Entering or staying in Idle never clears the channel error latches.
// - Idle pin high plus any control input or channel-on bit enters Active.
// - Without stay-active, Active returns to Idle once all requests vanish.
// - With stay-active set, Active is held regardless of requests.
// - Logic supply undervoltage with inputs low drops Active to Idle.
// - A high control input enters Active even if both maps are zero.
// - Idle pin low with a high control input enters Limp Home.
// - Limp Home answers reads but ignores every register write.
// - Entering Limp Home from Idle or Active forces battery and logic supply flags to one.
// - Limp Home reports mode field 01.
// - First command after Limp Home entry from Idle or Active sets the transmission error flag.
// - Limp Home forces open-load check off; other registers hold defaults.
// - Limp Home drives only channels 2 and 3 from their control inputs.
// - Turn-on outside Active or Limp Home waits for the mode transition.
// - Registers reset on logic undervoltage, idle pin low or soft reset.
// - Soft reset keeps error latches and reloads both supply flags from the present supply levels.
// - Any register reset restores maps and drops channels not held by inputs.
// - Battery undervoltage while operative sets the battery flag.
// - Battery flag clears on a status readout or soft reset after recovery, and in Sleep.
// - Logic-low flag set while low, cleared on readout after recovery.
// - Start up needs supply plus input or idle pin; power-on on threshold.
// - A turn-on request outside Active goes to Active or Limp by idle pin.
// - Battery undervoltage disables channels until the supply recovers.
// - Register access is refused while the idle pin and both control inputs are low.
`timescale 1ns/1ns
`include "switch_mode_defs.vh"
module switch_mode_controller #(
    parameter CHANNELS = 8,
    parameter TRANSITION_NS = `TRANSITION_NS
) (
    input wire clock,
    input wire sys_rst,
    input wire idle_pin,
    input wire [1:0] control_input_n,
    input wire logic_supply_uv,
    input wire logic_supply_low,
    input wire logic_above_lop,
    input wire battery_uv,
    input wire battery_above_op,
    input wire [CHANNELS-1:0] channel_fault,
    input wire frame_error,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata_q,
    output reg [CHANNELS-1:0] channel_out_q,
    output reg [1:0] mode_q,
    output reg transition_busy_q,
    output reg bus_refused_q,
    output reg open_load_check_q,
    output reg power_on_q
);

    localparam integer TRANS_CYCLES_RAW =
        (TRANSITION_NS + `CLOCK_NS - 1) / `CLOCK_NS;
    localparam integer TRANS_CYCLES =
        (TRANS_CYCLES_RAW < 1) ? 1 : TRANS_CYCLES_RAW;

    localparam SYNC_W = CHANNELS + 9;
    localparam [7:0] HW_CTRL_RST = `RST_HW_CTRL;

    wire [SYNC_W-1:0] sync_bus;
    wire idle_s;
    wire [1:0] ctrl_s;
    wire logic_uv_s;
    wire logic_low_s;
    wire logic_lop_s;
    wire batt_uv_s;
    wire batt_op_s;
    wire [CHANNELS-1:0] fault_s;
    wire frame_err_s;

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({frame_error, channel_fault, batt_op_raw(battery_above_op),
            battery_uv, logic_above_lop, logic_supply_low, logic_supply_uv,
            control_input_n, idle_pin}),
        .sync_out(sync_bus)
    );

    function batt_op_raw;
        input bit_in;
        begin
            batt_op_raw = bit_in;
        end
    endfunction

    assign idle_s = sync_bus[0];
    assign ctrl_s = sync_bus[2:1];
    assign logic_uv_s = sync_bus[3];
    assign logic_low_s = sync_bus[4];
    assign logic_lop_s = sync_bus[5];
    assign batt_uv_s = sync_bus[6];
    assign batt_op_s = sync_bus[7];
    assign fault_s = sync_bus[CHANNELS+7:8];
    assign frame_err_s = sync_bus[CHANNELS+8];

    // Channels requested by the two control inputs through their maps
    function [CHANNELS-1:0] input_drive;
        input [1:0] ctrl;
        input [CHANNELS-1:0] map0;
        input [CHANNELS-1:0] map1;
        begin
            input_drive = (ctrl[0] ? map0 : {CHANNELS{1'b0}})
                | (ctrl[1] ? map1 : {CHANNELS{1'b0}});
        end
    endfunction

    reg [CHANNELS-1:0] channel_on_q;
    reg [CHANNELS-1:0] map0_q;
    reg [CHANNELS-1:0] map1_q;
    reg stay_active_q;
    reg open_load_en_q;
    reg [CHANNELS-1:0] error_q;
    reg tx_error_q;
    reg batt_flag_q;
    reg logic_flag_q;
    reg limp_first_q;
    reg [1:0] target_q;
    reg [15:0] trans_cnt_q;

    reg [1:0] target_d;
    reg any_ctrl;
    reg any_on;
    reg in_limp;
    reg bus_ok;
    reg wr_ok;
    reg soft_reset;
    reg reg_reset;
    reg status_read;
    reg limp_entry;
    reg [CHANNELS-1:0] chan_d;

    always @* begin
        any_ctrl = |ctrl_s;
        any_on = |channel_on_q;
        in_limp = (mode_q == `MODE_LIMP);
        target_d = mode_q;
        if (!power_on_q) begin
            target_d = `MODE_SLEEP;
        end else if (!idle_s && !any_ctrl) begin
            target_d = `MODE_SLEEP;
        end else if (!idle_s) begin
            target_d = `MODE_LIMP;
        end else if (any_ctrl) begin
            target_d = `MODE_ACTIVE;
        end else if (logic_uv_s) begin
            target_d = `MODE_IDLE;
        end else if (any_on) begin
            target_d = `MODE_ACTIVE;
        end else if (stay_active_q && mode_q == `MODE_ACTIVE) begin
            target_d = `MODE_ACTIVE;
        end else begin
            target_d = `MODE_IDLE;
        end
        // Sleep and logic undervoltage shut the port, as does the idle-low
        // state with no inputs, where the device has no supply path
        bus_ok = power_on_q && !logic_uv_s && mode_q != `MODE_SLEEP
            && !(!idle_s && !any_ctrl) && !transition_busy_q;
        wr_ok = bus_ok && !in_limp && reg_write;
        soft_reset = wr_ok && reg_addr == `ADDR_HW_CTRL
            && reg_wdata[`HW_SOFT_RESET];
        reg_reset = logic_uv_s || !idle_s || soft_reset
            || mode_q == `MODE_SLEEP;
        status_read = bus_ok && reg_read && reg_addr == `ADDR_STATUS;
        limp_entry = transition_busy_q && trans_cnt_q == 16'h0001
            && target_q == `MODE_LIMP;
        chan_d = {CHANNELS{1'b0}};
        if (!transition_busy_q && !batt_uv_s) begin
            if (mode_q == `MODE_ACTIVE) begin
                chan_d = channel_on_q
                    | input_drive(ctrl_s, map0_q, map1_q);
            end else if (in_limp) begin
                chan_d = input_drive(ctrl_s, `RST_INPUT_ZERO_MAP,
                    `RST_INPUT_ONE_MAP);
            end
        end
    end

    // Power-on and mode sequencing
    always @(posedge clock) begin
        if (sys_rst) begin
            power_on_q <= 1'b0;
            mode_q <= `MODE_SLEEP;
            target_q <= `MODE_SLEEP;
            trans_cnt_q <= 16'h0000;
            transition_busy_q <= 1'b0;
        end else begin
            // Startup only once a supply clears its threshold and a pin wakes it
            if (batt_op_s || logic_lop_s) begin
                if (idle_s || any_ctrl) begin
                    power_on_q <= 1'b1;
                end
            end else if (logic_uv_s && !batt_op_s) begin
                power_on_q <= 1'b0;
            end
            if (transition_busy_q) begin
                // Responses are undefined here; the host holds off
                if (trans_cnt_q == 16'h0001) begin
                    mode_q <= target_q;
                    transition_busy_q <= 1'b0;
                    trans_cnt_q <= 16'h0000;
                end else begin
                    trans_cnt_q <= trans_cnt_q - 16'h0001;
                end
            end else if (target_d != mode_q) begin
                if (target_d == `MODE_SLEEP || target_d == `MODE_IDLE) begin
                    mode_q <= target_d;
                end else begin
                    target_q <= target_d;
                    trans_cnt_q <= TRANS_CYCLES[15:0];
                    transition_busy_q <= 1'b1;
                end
            end
        end
    end

    // Writable registers
    always @(posedge clock) begin
        if (sys_rst || reg_reset || in_limp) begin
            channel_on_q <= `RST_CHANNEL_ON;
            map0_q <= `RST_INPUT_ZERO_MAP;
            map1_q <= `RST_INPUT_ONE_MAP;
            stay_active_q <= HW_CTRL_RST[`HW_STAY_ACTIVE];
            open_load_en_q <= in_limp ? 1'b0
                : HW_CTRL_RST[`HW_OPEN_LOAD];
        end else if (wr_ok) begin
            case (reg_addr)
                `ADDR_CHANNEL_ON: begin
                    channel_on_q <= reg_wdata[CHANNELS-1:0];
                end
                `ADDR_HW_CTRL: begin
                    stay_active_q <= reg_wdata[`HW_STAY_ACTIVE];
                    open_load_en_q <= reg_wdata[`HW_OPEN_LOAD];
                end
                `ADDR_INPUT_ZERO_MAP: begin
                    map0_q <= reg_wdata[CHANNELS-1:0];
                end
                `ADDR_INPUT_ONE_MAP: begin
                    map1_q <= reg_wdata[CHANNELS-1:0];
                end
                default: begin
                    channel_on_q <= channel_on_q;
                end
            endcase
        end
    end

    // Error latches survive Idle and soft reset; only logic undervoltage or a host clear drops them
    always @(posedge clock) begin
        if (sys_rst || logic_uv_s) begin
            error_q <= {CHANNELS{1'b0}};
        end else begin
            // Set wins over clear; diagnosis runs only with channels able
            if (mode_q == `MODE_ACTIVE || in_limp) begin
                error_q <= (error_q & ~((wr_ok && reg_addr == `ADDR_ERROR)
                    ? reg_wdata[CHANNELS-1:0] : {CHANNELS{1'b0}}))
                    | fault_s;
            end else if (wr_ok && reg_addr == `ADDR_ERROR) begin
                error_q <= error_q & ~reg_wdata[CHANNELS-1:0];
            end
        end
    end

    // Supply flags and transmission error
    always @(posedge clock) begin
        if (sys_rst || mode_q == `MODE_SLEEP) begin
            batt_flag_q <= 1'b0;
            logic_flag_q <= 1'b0;
            tx_error_q <= 1'b0;
            limp_first_q <= 1'b0;
        end else if (limp_entry) begin
            batt_flag_q <= 1'b1;
            logic_flag_q <= 1'b1;
            limp_first_q <= 1'b1;
        end else if (soft_reset) begin
            batt_flag_q <= batt_uv_s;
            logic_flag_q <= logic_low_s;
        end else begin
            if (batt_uv_s) begin
                batt_flag_q <= 1'b1;
            end else if (status_read && batt_op_s) begin
                batt_flag_q <= 1'b0;
            end
            if (logic_low_s) begin
                logic_flag_q <= 1'b1;
            end else if (status_read) begin
                logic_flag_q <= 1'b0;
            end
            if (limp_first_q && bus_ok && (reg_read || reg_write)) begin
                tx_error_q <= 1'b1;
                limp_first_q <= 1'b0;
            end else if (frame_err_s) begin
                tx_error_q <= 1'b1;
            end else if (status_read) begin
                tx_error_q <= 1'b0;
            end
        end
    end

    // Read port and registered outputs
    always @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_q <= 8'h00;
            channel_out_q <= {CHANNELS{1'b0}};
            bus_refused_q <= 1'b1;
            open_load_check_q <= 1'b0;
        end else begin
            channel_out_q <= chan_d;
            bus_refused_q <= !bus_ok;
            open_load_check_q <= open_load_en_q && !in_limp
                && mode_q == `MODE_ACTIVE;
            reg_rdata_q <= 8'h00;
            if (bus_ok && reg_read) begin
                case (reg_addr)
                    `ADDR_CHANNEL_ON: begin
                        reg_rdata_q <= channel_on_q;
                    end
                    `ADDR_HW_CTRL: begin
                        reg_rdata_q <= {5'h00, open_load_en_q, 1'b0,
                            stay_active_q};
                    end
                    `ADDR_INPUT_ZERO_MAP: begin
                        reg_rdata_q <= map0_q;
                    end
                    `ADDR_INPUT_ONE_MAP: begin
                        reg_rdata_q <= map1_q;
                    end
                    `ADDR_STATUS: begin
                        reg_rdata_q <= {3'h0, logic_flag_q, batt_flag_q,
                            tx_error_q || (limp_first_q), mode_q};
                    end
                    `ADDR_ERROR: begin
                        reg_rdata_q <= error_q;
                    end
                    `ADDR_MONITOR: begin
                        reg_rdata_q <= channel_out_q;
                    end
                    default: begin
                        reg_rdata_q <= 8'h00;
                    end
                endcase
            end
        end
    end

endmodule // switch_mode_controller

// *** rtl/switch_mode_defs.vh ***
`ifndef SWITCH_MODE_DEFS_VH
`define SWITCH_MODE_DEFS_VH

// Register indices on the plain register port
`define ADDR_CHANNEL_ON 4'h0
`define ADDR_HW_CTRL 4'h1
`define ADDR_INPUT_ZERO_MAP 4'h2
`define ADDR_INPUT_ONE_MAP 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_ERROR 4'h5
`define ADDR_MONITOR 4'h6

// Hardware control register fields
`define HW_STAY_ACTIVE 0
`define HW_SOFT_RESET 1
`define HW_OPEN_LOAD 2

// Status register fields
`define ST_MODE_LO 0
`define ST_MODE_HI 1
`define ST_TX_ERROR 2
`define ST_BATT_UV 3
`define ST_LOGIC_LOW 4

// Reset values
`define RST_CHANNEL_ON 8'h00
`define RST_INPUT_ZERO_MAP 8'h04
`define RST_INPUT_ONE_MAP 8'h08
`define RST_HW_CTRL 8'h04

// Operating mode codes as reported in the status field
`define MODE_IDLE 2'h0
`define MODE_LIMP 2'h1
`define MODE_ACTIVE 2'h2
`define MODE_SLEEP 2'h3

// Mode transition latency
`define TRANSITION_NS 1000
`define CLOCK_NS 8

`endif

// *** rtl/pin_sync.v ***
`timescale 1ns/1ns
module pin_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule // pin_sync

// *** tb/switch_mode_checker.sv ***
`timescale 1ns/1ns
module switch_mode_checker #(
    parameter CHANNELS = 8
) (
    input wire clock,
    input wire sys_rst,
    input wire idle_pin,
    input wire [1:0] control_input_n,
    input wire battery_uv,
    input wire [3:0] reg_addr,
    input wire reg_read,
    input wire [7:0] reg_rdata_q,
    input wire [CHANNELS-1:0] channel_out_q,
    input wire [1:0] mode_q,
    input wire transition_busy_q,
    input wire bus_refused_q,
    input wire open_load_check_q
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Pins pass two sync flops, so conditions must hold a few cycles
    sequence s_sleep_pins;
        (!idle_pin && control_input_n == 2'h0) [*5];
    endsequence
    sequence s_limp_both;
        (mode_q == 2'h1 && control_input_n == 2'h3 && !battery_uv
            && !transition_busy_q) [*5];
    endsequence
    sequence s_limp_status;
        (mode_q == 2'h1 && reg_read && reg_addr == 4'h4 && !bus_refused_q)
            ##1 mode_q == 2'h1;
    endsequence
    property p_sleep_entry;
        s_sleep_pins |=> mode_q == 2'h3;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");
    property p_sleep_off;
        mode_q == 2'h3 [*2] |-> channel_out_q == 8'h00;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("channel on in sleep");
    property p_sleep_refuse;
        mode_q == 2'h3 [*2] |-> bus_refused_q;
    endproperty
    a_sleep_refuse: assert property (p_sleep_refuse)
        else $error("bus open in sleep");
    property p_limp_chans;
        mode_q == 2'h1 [*2] |-> (channel_out_q & 8'hF3) == 8'h00;
    endproperty
    a_limp_chans: assert property (p_limp_chans)
        else $error("wrong channel in limp home");
    property p_limp_drive;
        s_limp_both |-> channel_out_q == 8'h0C;
    endproperty
    a_limp_drive: assert property (p_limp_drive)
        else $error("limp home inputs not driving");
    property p_limp_olc;
        mode_q == 2'h1 [*2] |-> !open_load_check_q;
    endproperty
    a_limp_olc: assert property (p_limp_olc)
        else $error("open load check in limp home");
    property p_limp_status;
        s_limp_status |-> reg_rdata_q[1:0] == 2'h1;
    endproperty
    a_limp_status: assert property (p_limp_status)
        else $error("mode field wrong in limp home");
    property p_batt_off;
        battery_uv [*5] |-> channel_out_q == 8'h00;
    endproperty
    a_batt_off: assert property (p_batt_off)
        else $error("channel on in battery undervoltage");
    property p_trans_off;
        (transition_busy_q && mode_q == 2'h0) [*2] |-> channel_out_q == 8'h00;
    endproperty
    a_trans_off: assert property (p_trans_off)
        else $error("channel on before transition end");
endmodule // switch_mode_checker

bind switch_mode_controller switch_mode_checker #(.CHANNELS(CHANNELS)) chk_u (
    .clock(clock), .sys_rst(sys_rst), .idle_pin(idle_pin),
    .control_input_n(control_input_n), .battery_uv(battery_uv),
    .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .channel_out_q(channel_out_q), .mode_q(mode_q),
    .transition_busy_q(transition_busy_q), .bus_refused_q(bus_refused_q),
    .open_load_check_q(open_load_check_q));

// *** tb/host_model.sv ***
`timescale 1ns/1ns
module host_model (
    input wire clock,
    input wire transition_busy_q,
    input wire [7:0] reg_rdata_q,
    output reg [3:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_write,
    output reg reg_read
);
    initial begin
        reg_addr = 4'hF;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    task acc(input w, input [3:0] a, input [7:0] d, output [7:0] q);
        begin
            #1;
            while (transition_busy_q) @(posedge clock) #1;
            @(posedge clock);
            reg_write <= w;
            reg_read <= !w;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge clock);
            reg_write <= 1'b0;
            reg_read <= 1'b0;
            // Released lines flip so stale values cannot pass
            reg_addr <= ~a;
            reg_wdata <= ~d;
            #1 q = reg_rdata_q;
        end
    endtask
endmodule // host_model

// *** tb/tb_switch_mode_controller.sv ***
`timescale 1ns/1ns
`include "switch_mode_defs.vh"
module tb_switch_mode_controller;
    reg clock = 1'b0;
    reg sys_rst = 1'b1;
    reg idle_pin = 1'b0;
    reg [1:0] control_input_n = 2'h0;
    reg logic_supply_uv = 1'b0;
    reg logic_supply_low = 1'b0;
    reg logic_above_lop = 1'b1;
    reg battery_uv = 1'b0;
    reg battery_above_op = 1'b1;
    reg [7:0] channel_fault = 8'h00;
    reg frame_error = 1'b0;
    wire [3:0] reg_addr;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata_q;
    wire [7:0] channel_out_q;
    wire [1:0] mode_q;
    wire reg_write, reg_read, transition_busy_q, bus_refused_q;
    wire open_load_check_q, power_on_q;
    integer fails = 0;
    integer compares = 0;
    integer seed = 75;
    reg [31:0] x;
    reg [7:0] v, f, r;
    always #4 clock = ~clock;
    // Short transition keeps the run brief: 80 ns is 10 cycles
    switch_mode_controller #(.TRANSITION_NS(80)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .idle_pin(idle_pin),
        .control_input_n(control_input_n), .logic_supply_uv(logic_supply_uv),
        .logic_supply_low(logic_supply_low), .logic_above_lop(logic_above_lop),
        .battery_uv(battery_uv), .battery_above_op(battery_above_op),
        .channel_fault(channel_fault), .frame_error(frame_error),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
        .channel_out_q(channel_out_q), .mode_q(mode_q),
        .transition_busy_q(transition_busy_q), .bus_refused_q(bus_refused_q),
        .open_load_check_q(open_load_check_q), .power_on_q(power_on_q));
    host_model host_u (
        .clock(clock), .transition_busy_q(transition_busy_q),
        .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
    task end_sim;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wait_mode(input [1:0] m);
        begin
            repeat (60) if (mode_q !== m) @(posedge clock) #1;
            repeat (3) @(posedge clock);
            #1 chk({6'h00, mode_q}, {6'h00, m});
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        host_u.acc(1'b1, a, d, r);
    endtask
    task rdchk(input [3:0] a, input [7:0] e);
        begin
            host_u.acc(1'b0, a, 8'h00, r);
            chk(r, e);
        end
    endtask
    task pins(input i, input [1:0] c);
        begin
            @(posedge clock);
            idle_pin <= i;
            control_input_n <= c;
        end
    endtask
    task supply(input bu, input ll);
        begin
            @(posedge clock);
            battery_uv <= bu;
            battery_above_op <= !bu;
            logic_supply_low <= ll;
            logic_above_lop <= !ll;
            repeat (6) @(posedge clock);
            #1;
        end
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        x = $random(seed);
        v = x[7:0] | 8'h01;
        f = x[15:8] | 8'h80;
        wait_mode(`MODE_SLEEP);
        chk({7'h00, bus_refused_q}, 8'h01);
        rdchk(`ADDR_STATUS, 8'h00);
        pins(1'b1, 2'h0);
        wait_mode(`MODE_IDLE);
        chk({7'h00, power_on_q}, 8'h01);
        chk(channel_out_q, 8'h00);
        chk({7'h00, open_load_check_q}, 8'h00);
        chk({7'h00, bus_refused_q}, 8'h00);
        rdchk(`ADDR_HW_CTRL, `RST_HW_CTRL);
        rdchk(`ADDR_INPUT_ZERO_MAP, `RST_INPUT_ZERO_MAP);
        rdchk(`ADDR_INPUT_ONE_MAP, `RST_INPUT_ONE_MAP);
        rdchk(4'hA, 8'h00);
        wr(`ADDR_CHANNEL_ON, v);
        wait_mode(`MODE_ACTIVE);
        chk(channel_out_q, v);
        @(posedge clock);
        channel_fault <= f;
        repeat (3) @(posedge clock);
        channel_fault <= 8'h00;
        wr(`ADDR_HW_CTRL, 8'h05);
        @(posedge clock);
        #1 chk({7'h00, open_load_check_q}, 8'h01);
        supply(1'b1, 1'b0);
        chk(channel_out_q, 8'h00);
        rdchk(`ADDR_STATUS, 8'h0A);
        supply(1'b0, 1'b0);
        chk(channel_out_q, v);
        rdchk(`ADDR_STATUS, 8'h0A);
        rdchk(`ADDR_STATUS, 8'h02);
        supply(1'b0, 1'b1);
        rdchk(`ADDR_STATUS, 8'h12);
        supply(1'b0, 1'b0);
        rdchk(`ADDR_STATUS, 8'h12);
        rdchk(`ADDR_STATUS, 8'h02);
        frame_error <= 1'b1;
        @(posedge clock);
        frame_error <= 1'b0;
        repeat (3) @(posedge clock);
        rdchk(`ADDR_STATUS, 8'h06);
        rdchk(`ADDR_STATUS, 8'h02);
        supply(1'b1, 1'b1);
        supply(1'b0, 1'b0);
        wr(`ADDR_CHANNEL_ON, 8'h00);
        repeat (30) @(posedge clock);
        wait_mode(`MODE_ACTIVE);
        wr(`ADDR_HW_CTRL, 8'h02);
        wait_mode(`MODE_IDLE);
        rdchk(`ADDR_HW_CTRL, `RST_HW_CTRL);
        rdchk(`ADDR_ERROR, f);
        rdchk(`ADDR_STATUS, 8'h00);
        wr(`ADDR_INPUT_ZERO_MAP, 8'h00);
        wr(`ADDR_INPUT_ONE_MAP, 8'h00);
        pins(1'b1, 2'h1);
        wait_mode(`MODE_ACTIVE);
        chk(channel_out_q, 8'h00);
        wr(`ADDR_HW_CTRL, 8'h02);
        repeat (4) @(posedge clock);
        #1 chk(channel_out_q, 8'h04);
        wr(`ADDR_HW_CTRL, 8'h05);
        pins(1'b1, 2'h0);
        repeat (20) @(posedge clock);
        logic_supply_uv <= 1'b1;
        wait_mode(`MODE_IDLE);
        logic_supply_uv <= 1'b0;
        // The port stays shut until the released level clears the sync flops
        repeat (4) @(posedge clock);
        rdchk(`ADDR_HW_CTRL, `RST_HW_CTRL);
        pins(1'b0, 2'h1);
        wait_mode(`MODE_LIMP);
        chk(channel_out_q, 8'h04);
        chk({7'h00, open_load_check_q}, 8'h00);
        rdchk(`ADDR_STATUS, 8'h1D);
        rdchk(`ADDR_STATUS, 8'h05);
        rdchk(`ADDR_STATUS, 8'h01);
        wr(`ADDR_CHANNEL_ON, 8'hFF);
        rdchk(`ADDR_CHANNEL_ON, `RST_CHANNEL_ON);
        pins(1'b0, 2'h3);
        repeat (6) @(posedge clock);
        #1 chk(channel_out_q, 8'h0C);
        pins(1'b0, 2'h0);
        wait_mode(`MODE_SLEEP);
        chk(channel_out_q, 8'h00);
        rdchk(`ADDR_STATUS, 8'h00);
        end_sim;
    end
endmodule // tb_switch_mode_controller
